// ==== hdl/ddc_device.sv ====
// Purpose: converter end of the serial command port and its registers
// Assumes: link pins asynchronous; serial clock levels last 3+ hclk cycles
// Notes: outputs are the channel input/active codes, power-down flags and frame done/ignored pulses
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module ddc_device #(
    parameter int CODE_BITS = ddc_pkg::DATA_BITS
) (
    input  wire logic                                   hclk,
    input  wire logic                                   hresetn,
    ddc_if.device                                       link,
    output logic [ddc_pkg::CHANNELS-1:0][CODE_BITS-1:0] input_code,
    output logic [ddc_pkg::CHANNELS-1:0][CODE_BITS-1:0] dac_code,
    output logic [ddc_pkg::CHANNELS-1:0]                power_down,
    output logic                                        frame_done,
    output logic                                        frame_ignored
);
    import ddc_pkg::*;

    logic [2:0]                          pins;
    logic                                cs_now;
    logic                                sck_now;
    logic                                sdi_now;
    logic                                cs_d_ff;
    logic                                sck_d_ff;
    logic                                cs_rise;
    logic                                cs_fall;
    logic                                sck_rise;
    logic [LONG_BITS-1:0]                shift_ff;
    logic [LONG_BITS-1:0]                nxt_shift;
    logic [5:0]                          count_ff;
    logic [5:0]                          nxt_count;
    logic [3:0]                          cmd;
    logic [3:0]                          chan;
    logic [CODE_BITS-1:0]                code;
    logic [CHANNELS-1:0]                 mask;
    logic                                reject;
    logic [CHANNELS-1:0][CODE_BITS-1:0]  in_ff;
    logic [CHANNELS-1:0][CODE_BITS-1:0]  nxt_in;
    logic [CHANNELS-1:0][CODE_BITS-1:0]  dac_ff;
    logic [CHANNELS-1:0][CODE_BITS-1:0]  nxt_dac;
    logic [CHANNELS-1:0]                 pd_ff;
    logic [CHANNELS-1:0]                 nxt_pd;
    logic                                done_ff;
    logic                                nxt_done;
    logic                                ign_ff;
    logic                                nxt_ign;

    // channel code to per-channel select mask; unknown codes select none
    function automatic logic [CHANNELS-1:0] chan_mask(input logic [3:0] c);
        logic [CHANNELS-1:0] m;
        m = '0;
        case (c)
            CHAN_A:   m = 2'b01;
            CHAN_B:   m = 2'b10;
            CHAN_ALL: m = 2'b11;
            default:  m = '0;
        endcase
        return m;
    endfunction

    // all three wires share one delay, so data stays aligned to its clock
    ddc_sync #(
        .WIDTH   (3),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({link.select_and_load, link.serial_clock, link.serial_data_in}),
        .dout    (pins)
    );

    assign cs_now   = pins[2];
    assign sck_now  = pins[1];
    assign sdi_now  = pins[0];
    assign cs_rise  = cs_now & ~cs_d_ff;
    assign cs_fall  = ~cs_now & cs_d_ff;
    assign sck_rise = sck_now & ~sck_d_ff;

    // edge history of the filtered select and clock pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_d_ff  <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            cs_d_ff  <= cs_now;
            sck_d_ff <= sck_now;
        end
    end

    // shift register, enabled only while select is low
    always_comb begin
        nxt_shift = shift_ff;
        nxt_count = count_ff;
        if (cs_fall) begin
            nxt_count = '0; // new frame starts counting afresh
        end
        if (!cs_now && sck_rise) begin
            nxt_shift = {shift_ff[LONG_BITS-2:0], sdi_now};
            if (nxt_count < 6'(LONG_BITS)) begin
                nxt_count = nxt_count + 6'd1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_ff <= '0;
            count_ff <= '0;
        end else begin
            shift_ff <= nxt_shift;
            count_ff <= nxt_count;
        end
    end

    // the newest 24 bits form the word; any leading pad has shifted past
    assign cmd  = shift_ff[WORD_BITS-1 -: 4];
    assign chan = shift_ff[WORD_BITS-5 -: 4];
    assign code = shift_ff[DATA_BITS-1 -: CODE_BITS];
    assign mask = chan_mask(chan);
    // short frames and reserved channel codes change nothing
    assign reject = (count_ff < 6'(WORD_BITS)) || (mask == '0);

    // command execution on the select rising edge
    always_comb begin
        nxt_in   = in_ff;
        nxt_dac  = dac_ff;
        nxt_pd   = pd_ff;
        nxt_done = 1'b0;
        nxt_ign  = 1'b0;
        if (cs_rise) begin
            nxt_done = ~reject;
            nxt_ign  = reject;
            if (!reject) begin
                case (cmd)
                    CMD_WRITE: begin
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (mask[i]) begin
                                nxt_in[i] = code;
                            end
                        end
                    end
                    CMD_UPDATE: begin
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (mask[i]) begin
                                nxt_dac[i] = in_ff[i];
                                nxt_pd[i]  = 1'b0;
                            end
                        end
                    end
                    CMD_WRITE_ALL: begin
                        // every channel updates from its input register; selected channels use the freshly written value
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (mask[i]) begin
                                nxt_in[i] = code;
                            end
                            nxt_dac[i] = nxt_in[i];
                            nxt_pd[i]  = 1'b0;
                        end
                    end
                    CMD_WRITE_UPD: begin
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (mask[i]) begin
                                nxt_in[i]  = code;
                                nxt_dac[i] = code;
                                nxt_pd[i]  = 1'b0;
                            end
                        end
                    end
                    CMD_POWER_DOWN: begin
                        // data word unused; codes stay as they were
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (mask[i]) begin
                                nxt_pd[i] = 1'b1;
                            end
                        end
                    end
                    CMD_NOP: begin
                        nxt_done = 1'b1;
                    end
                    default: begin
                        nxt_done = 1'b0;
                        nxt_ign  = 1'b1;
                    end
                endcase
            end
        end
    end

    // zero-scale codes and powered-up channels from reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                in_ff[i]  <= CODE_RST[DATA_BITS-1 -: CODE_BITS];
                dac_ff[i] <= CODE_RST[DATA_BITS-1 -: CODE_BITS];
            end
            pd_ff   <= '0;
            done_ff <= 1'b0;
            ign_ff  <= 1'b0;
        end else begin
            in_ff   <= nxt_in;
            dac_ff  <= nxt_dac;
            pd_ff   <= nxt_pd;
            done_ff <= nxt_done;
            ign_ff  <= nxt_ign;
        end
    end

    assign input_code    = in_ff;
    assign dac_code      = dac_ff;
    assign power_down    = pd_ff;
    assign frame_done    = done_ff;
    assign frame_ignored = ign_ff;
endmodule

// ==== hdl/ddc_host.sv ====
// Purpose: host end: AHB-Lite registers that send one command frame each
// Assumes: single word transfers; the bus never needs wait states here
// Notes: serial clock made by a divider of hclk and driven out
`timescale 1ns/100ps
module ddc_host #(
    parameter int SCK_HALF = ddc_pkg::SCK_HALF_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    ddc_if.host              link
);
    import ddc_pkg::*;

    typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_SHIFT, HS_TRAIL, HS_GAP} ddc_hstate_type;

    ddc_hstate_type  state_ff;
    ddc_hstate_type  nxt_state;
    logic [7:0]      div_ff;
    logic [7:0]      nxt_div;
    logic [5:0]      bits_ff;
    logic [5:0]      nxt_bits;
    logic [31:0]     shreg_ff;
    logic [31:0]     nxt_shreg;
    logic            cs_ff;
    logic            nxt_cs;
    logic            sck_ff;
    logic            nxt_sck;
    logic            sdo_ff;
    logic            nxt_sdo;
    logic            tick;
    logic            busy;
    logic            start;
    logic [23:0]     word_ff;
    logic [23:0]     nxt_word;
    logic            long_ff;
    logic            nxt_long;
    logic            wpend_ff;
    logic [7:0]      waddr_ff;
    logic [31:0]     rdata_ff;
    logic [31:0]     nxt_rdata;
    logic            take;

    assign busy  = (state_ff != HS_IDLE);
    assign tick  = (div_ff == 8'(SCK_HALF - 1));
    assign take  = hsel && hready && htrans[1];
    assign start = wpend_ff && (waddr_ff == REG_CTRL) && hwdata[CTRL_GO] && !busy;

    // bus side: zero wait states, reads answered from the address phase
    always_comb begin
        nxt_word  = word_ff;
        nxt_long  = long_ff;
        nxt_rdata = rdata_ff;
        // writes while a frame is in flight are dropped
        if (wpend_ff && !busy) begin
            if (waddr_ff == REG_WORD) begin
                nxt_word = hwdata[23:0];
            end
            if (waddr_ff == REG_CTRL) begin
                nxt_long = hwdata[CTRL_LONG];
            end
        end
        if (take && !hwrite) begin
            case (haddr[7:0])
                REG_WORD:   nxt_rdata = {8'h00, word_ff};
                REG_CTRL:   nxt_rdata = {31'h0000_0000, long_ff};
                REG_STATUS: nxt_rdata = {31'h0000_0000, busy};
                default:    nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_ff   <= WORD_RST;
            long_ff   <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            wpend_ff  <= 1'b0;
            waddr_ff  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            word_ff   <= nxt_word;
            long_ff   <= nxt_long;
            rdata_ff  <= nxt_rdata;
            wpend_ff  <= take && hwrite;
            waddr_ff  <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = rdata_ff;

    // frame sequencer; data changes on the falling serial clock edge
    always_comb begin
        nxt_state = state_ff;
        nxt_div   = busy ? (tick ? 8'h00 : div_ff + 8'h01) : 8'h00;
        nxt_bits  = bits_ff;
        nxt_shreg = shreg_ff;
        nxt_cs    = cs_ff;
        nxt_sck   = sck_ff;
        nxt_sdo   = sdo_ff;
        case (state_ff)
            HS_IDLE: begin
                if (start) begin
                    // long frame: 8 pad bits ahead of the 24-bit word
                    nxt_shreg = hwdata[CTRL_LONG] ? {8'h00, word_ff} : {word_ff, 8'h00};
                    nxt_bits  = hwdata[CTRL_LONG] ? 6'(LONG_BITS) : 6'(WORD_BITS);
                    nxt_sdo   = hwdata[CTRL_LONG] ? 1'b0 : word_ff[23];
                    nxt_cs    = 1'b0;
                    nxt_state = HS_LEAD;
                end
            end
            HS_LEAD: begin
                if (tick) begin
                    nxt_sck   = 1'b1;
                    nxt_state = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                if (tick) begin
                    nxt_sck = ~sck_ff;
                    if (sck_ff) begin
                        nxt_bits = bits_ff - 6'd1;
                        if (bits_ff == 6'd1) begin
                            nxt_state = HS_TRAIL;
                        end else begin
                            nxt_shreg = {shreg_ff[30:0], 1'b0};
                            nxt_sdo   = shreg_ff[30];
                        end
                    end
                end
            end
            HS_TRAIL: begin
                if (tick) begin
                    nxt_cs    = 1'b1;
                    nxt_state = HS_GAP;
                end
            end
            HS_GAP: begin
                if (tick) begin
                    nxt_state = HS_IDLE;
                end
            end
            default: begin
                nxt_state = HS_IDLE;
                nxt_cs    = 1'b1;
                nxt_sck   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= HS_IDLE;
            div_ff   <= 8'h00;
            bits_ff  <= 6'd0;
            shreg_ff <= 32'h0000_0000;
            cs_ff    <= 1'b1;
            sck_ff   <= 1'b0;
            sdo_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            div_ff   <= nxt_div;
            bits_ff  <= nxt_bits;
            shreg_ff <= nxt_shreg;
            cs_ff    <= nxt_cs;
            sck_ff   <= nxt_sck;
            sdo_ff   <= nxt_sdo;
        end
    end

    // codes sent are whatever software wrote; legal ones are its duty
    assign link.select_and_load = cs_ff;
    assign link.serial_clock    = sck_ff;
    assign link.serial_data_in  = sdo_ff;
endmodule

// ==== hdl/ddc_if.sv ====
// Purpose: three-wire serial command link between host and converter
// Assumes: host drives every wire, device only listens
// Notes: write-only link, no wire turns around
`timescale 1ns/100ps
interface ddc_if;
    logic select_and_load;
    logic serial_clock;
    logic serial_data_in;

    modport host (
        output select_and_load,
        output serial_clock,
        output serial_data_in
    );
    modport device (
        input select_and_load,
        input serial_clock,
        input serial_data_in
    );
endinterface

// ==== hdl/ddc_pkg.sv ====
// Purpose: shared constants of the dual-channel converter serial command port
// Assumes: 100 MHz hclk; the host makes the serial clock by a divider
package ddc_pkg;
    localparam int          DATA_BITS      = 16;
    localparam int          WORD_BITS      = 24;
    localparam int          LONG_BITS      = 32;
    localparam int          CHANNELS       = 2;
    // command and channel codes
    localparam logic [3:0]  CMD_WRITE      = 4'h0;
    localparam logic [3:0]  CMD_UPDATE     = 4'h1;
    localparam logic [3:0]  CMD_WRITE_ALL  = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPD  = 4'h3;
    localparam logic [3:0]  CMD_POWER_DOWN = 4'h4;
    localparam logic [3:0]  CMD_NOP        = 4'hf;
    localparam logic [3:0]  CHAN_A         = 4'h0;
    localparam logic [3:0]  CHAN_B         = 4'h1;
    localparam logic [3:0]  CHAN_ALL       = 4'hf;
    // reset values
    localparam logic [DATA_BITS-1:0] CODE_RST = 16'h0000;
    localparam logic [2:0]  PIN_RST        = 3'h4;
    // host register map (byte offsets)
    localparam logic [7:0]  REG_WORD       = 8'h00;
    localparam logic [7:0]  REG_CTRL       = 8'h04;
    localparam logic [7:0]  REG_STATUS     = 8'h08;
    localparam int          CTRL_LONG      = 0;
    localparam int          CTRL_GO        = 1;
    localparam int          STAT_BUSY      = 0;
    localparam logic [23:0] WORD_RST       = 24'h00_0000;
    // timing
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          T_SCK_HALF_NS  = 40;
    localparam int          SCK_HALF_CYC   = (T_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== hdl/ddc_sync.sv ====
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs asynchronous to hclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
module ddc_sync #(
    parameter int               WIDTH   = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] filt_ff;
    logic [WIDTH-1:0] nxt_filt;

    // per bit: take the new level only once two stages match
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_filt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : filt_ff[i];
        end
    end

    // stage one feeds stage two only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_ff   <= RST_VAL;
            s2_ff   <= RST_VAL;
            s3_ff   <= RST_VAL;
            filt_ff <= RST_VAL;
        end else begin
            s1_ff   <= din;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    assign dout = filt_ff;
endmodule

// ==== tb/ddc_link_sva.sv ====
// Purpose: watches the serial command link between host and converter end
// Assumes: one domain on hclk, async active-low reset
// Notes: SCK_HALF must match the host instance
`timescale 1ns/100ps
module ddc_link_sva #(
    parameter int SCK_HALF = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic select_and_load,
    input wire logic serial_clock,
    input wire logic serial_data_in
);
    logic       sck_ff;
    logic       cs_ff;
    logic [7:0] len_ff;
    logic [5:0] rise_ff;
    logic [7:0] nxt_len;
    logic [5:0] nxt_rise;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // level length and rise count; length saturates so long gaps never wrap
    always_comb begin
        nxt_len  = (serial_clock != sck_ff) ? 8'h01 : len_ff + {7'h00, len_ff != 8'hff};
        nxt_rise = rise_ff;
        if (cs_ff && !select_and_load) begin
            nxt_rise = 6'h00;
        end else if (!select_and_load && serial_clock && !sck_ff) begin
            nxt_rise = rise_ff + 6'h01;
        end
    end

    // helper registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_ff  <= 1'b0;
            cs_ff   <= 1'b1;
            len_ff  <= 8'h00;
            rise_ff <= 6'h00;
        end else begin
            sck_ff  <= serial_clock;
            cs_ff   <= select_and_load;
            len_ff  <= nxt_len;
            rise_ff <= nxt_rise;
        end
    end

    // frame opening and closing steps
    sequence lead_s;
        (!serial_clock)[*4] ##1 serial_clock;
    endsequence
    sequence gap_s;
        select_and_load[*4];
    endsequence

    AST_LEAD: assert property ($fell(select_and_load) |-> lead_s)
        else $error("serial clock lead after select fall wrong");
    AST_IDLE: assert property (select_and_load |-> !serial_clock)
        else $error("serial clock moved while select high");
    AST_SETUP: assert property (serial_clock |-> $stable(serial_data_in))
        else $error("data changed around a rising serial clock");
    AST_HIGH: assert property ($fell(serial_clock) |-> int'(len_ff) == SCK_HALF)
        else $error("serial clock high time wrong");
    AST_LOW: assert property ($rose(serial_clock) && rise_ff != 6'h00 |-> int'(len_ff) == SCK_HALF)
        else $error("serial clock low time wrong");
    AST_COUNT: assert property ($rose(select_and_load) |-> rise_ff == 6'h18 || rise_ff == 6'h20)
        else $error("frame length not 24 or 32 bits");
    AST_TRAIL: assert property ($rose(select_and_load) |-> !serial_clock && int'(len_ff) == SCK_HALF)
        else $error("select rose too soon after last clock");
    AST_GAP: assert property ($rose(select_and_load) |-> gap_s)
        else $error("select high gap too short");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: drives the host over AHB-Lite and checks the converter end
// Assumes: default parameters, 100 MHz hclk
// Notes: a second converter end is driven directly to break link rules
`timescale 1ns/100ps
module tb_top;
    import ddc_pkg::*;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic             hreadyout;
    logic             hresp;
    logic [31:0]      hrdata;
    logic [1:0][15:0] icode, dcode, icode2, dcode2, ei, ed;
    logic [1:0]       pdn, pdn2, ep;
    logic             done, ign, done2, ign2;
    int               bad_count, total_checks, done_n, ign_n, ign2_n, done2_n, exp_d, exp_g;
    ddc_if link ();
    ddc_if link2 ();

    ddc_host ddc_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link(link));
    ddc_device ddc_device_i (.hclk, .hresetn, .link(link), .input_code(icode),
        .dac_code(dcode), .power_down(pdn), .frame_done(done), .frame_ignored(ign));
    ddc_device ddc_device_b_i (.hclk, .hresetn, .link(link2), .input_code(icode2),
        .dac_code(dcode2), .power_down(pdn2), .frame_done(done2), .frame_ignored(ign2));
    ddc_link_sva ddc_link_sva_i (.hclk, .hresetn, .select_and_load(link.select_and_load),
        .serial_clock(link.serial_clock), .serial_data_in(link.serial_data_in));

    // 100 MHz clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // pulse counters, sampled at the edge after each one-cycle pulse
    always @(posedge hclk) begin
        if (done === 1'b1) done_n++;
        if (ign === 1'b1) ign_n++;
        if (ign2 === 1'b1) ign2_n++;
        if (done2 === 1'b1) done2_n++;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // bounded wait for hready high at a rising edge
    task automatic wt();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 99) begin
                bad_count++;
                results();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wt();
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        q = hrdata;
        chk("bus response", hresp, 32'h0000_0000);
    endtask

    // compare converter outputs against the running model
    task automatic chk_all();
        for (int i = 0; i < 2; i++) begin
            chk("input code", icode[i], ei[i]);
            chk("active code", dcode[i], ed[i]);
        end
        chk("power down", pdn, ep);
        chk("done count", done_n, exp_d);
        chk("ignored count", ign_n, exp_g);
    endtask

    // send one frame through the host, then update the model and compare
    task automatic cmd(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] d,
                       input logic lng);
        logic [31:0] q;
        logic [1:0]  sel;
        int          n;
        sel = (ch == CHAN_A) ? 2'b01 : (ch == CHAN_B) ? 2'b10 : (ch == CHAN_ALL) ? 2'b11 : 2'b00;
        bus(REG_WORD, 1'b1, {8'h00, c, ch, d}, q);
        bus(REG_CTRL, 1'b1, {30'h0000_0000, 1'b1, lng}, q);
        bus(REG_WORD, 1'b1, 32'h00ff_ffff, q);
        n = 0;
        do begin
            bus(REG_STATUS, 1'b0, 32'h0000_0000, q);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (n >= 200) begin
            bad_count++;
            results();
        end
        repeat (8) @(posedge hclk);
        bus(REG_WORD, 1'b0, 32'h0000_0000, q);
        chk("word while busy", q, {8'h00, c, ch, d});
        if (sel == 2'b00 || !(c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf})) begin
            exp_g++;
        end else begin
            exp_d++;
            for (int i = 0; i < 2; i++) begin
                if (sel[i] && c inside {CMD_WRITE, CMD_WRITE_ALL, CMD_WRITE_UPD}) ei[i] = d;
                if ((sel[i] && c inside {CMD_UPDATE, CMD_WRITE_UPD}) || c == CMD_WRITE_ALL) begin
                    ed[i] = ei[i];
                    ep[i] = 1'b0;
                end
                if (sel[i] && c == CMD_POWER_DOWN) ep[i] = 1'b1;
            end
        end
        chk_all();
    endtask

    // bench acts as host on the second link; first pre bits go with select high
    task automatic bb(input logic [23:0] w, input int pre, input int n);
        for (int k = 23; k > 23 - pre - n; k--) begin
            link2.select_and_load <= (k > 23 - pre);
            link2.serial_data_in  <= w[k];
            repeat (4) @(posedge hclk);
            link2.serial_clock <= 1'b1;
            repeat (4) @(posedge hclk);
            link2.serial_clock <= 1'b0;
        end
        repeat (4) @(posedge hclk);
        link2.select_and_load <= 1'b1;
        link2.serial_data_in  <= ~link2.serial_data_in;
        repeat (12) @(posedge hclk);
    endtask

    // main sequence
    initial begin
        logic [31:0] q;
        hresetn = 1'b0;
        hsel    = 1'b1;
        haddr   = 32'h0000_0000;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0000_0000;
        link2.select_and_load = 1'b1;
        link2.serial_clock    = 1'b0;
        link2.serial_data_in  = 1'b0;
        ei = {CODE_RST, CODE_RST};
        ed = {CODE_RST, CODE_RST};
        ep = 2'b00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_all();
        for (int k = 0; k < 4; k++) begin
            bus(8'(k * 4), 1'b0, 32'h0000_0000, q);
            chk("register reset", q, 32'h0000_0000);
        end
        cmd(CMD_WRITE, CHAN_A, 16'h1234, 1'b0);
        cmd(CMD_UPDATE, CHAN_A, 16'h0000, 1'b0);
        cmd(CMD_WRITE, CHAN_B, 16'hbeef, 1'b1);
        cmd(CMD_POWER_DOWN, CHAN_ALL, 16'hffff, 1'b0);
        cmd(CMD_WRITE_UPD, CHAN_B, 16'h4321, 1'b1);
        cmd(CMD_WRITE_ALL, CHAN_A, 16'h5555, 1'b0);
        cmd(CMD_NOP, CHAN_ALL, 16'h0000, 1'b0);
        cmd(4'h5, CHAN_A, 16'h1111, 1'b0);
        cmd(CMD_WRITE, 4'h2, 16'h2222, 1'b0);
        cmd(CMD_POWER_DOWN, CHAN_A, 16'h0000, 1'b1);
        cmd(CMD_WRITE_ALL, CHAN_ALL, 16'h0f0f, 1'b1);
        bb(24'h30_abcd, 8, 16);
        // an accepted short frame would write channel A input, so look there
        chk("short frame code", icode2, 32'h0000_0000);
        chk("short frame flag", ign2_n, 1);
        bb(24'h30_abcd, 0, 24);
        chk("direct frame code", dcode2, 32'h0000_abcd);
        bb(24'h41_0000, 0, 24);
        chk("direct power down", pdn2, 32'h0000_0002);
        chk("direct frame done", done2_n, 2);
        results();
    end
endmodule
